// ### hdl/cise_elem.sv
// Module: one configurable flip-flop or latch storage element
`timescale 1ns/1ns
module cise_elem
    import cise_pkg::*;
(
    input  logic       clk,
    input  logic       rst_n,
    cise_elem_if.elem  e
);

    logic q_r;
    logic k_prev_r;
    logic rise;

    // ***************************************
    // Edge detect on the user clock level
    // ***************************************
    // No reset: the first sample only follows the level
    always_ff @(posedge clk) begin
        k_prev_r <= e.k;
    end

    assign rise = e.k & ~k_prev_r;

    // ***************************************
    // Storage
    // ***************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_r <= e.srval;
        end else if (e.sr) begin
            q_r <= e.srval;
        end else if (e.ce && (e.latch ? e.k : rise)) begin
            q_r <= e.d;
        end
    end

    // Force and transparency bypass the register so they act without a clock
    assign e.q = e.sr ? e.srval : ((e.latch && e.ce && e.k) ? e.d : q_r);

    // ***************************************
    // Checks
    // ***************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_hold;
        !e.sr && !e.ce;
    endsequence

    sequence s_load_edge;
        !e.latch && !e.sr && e.ce && e.k && !k_prev_r;
    endsequence

    AST_SR_FORCE: assert property (e.sr |=> q_r == $past(e.srval))
        else $error("Set/reset did not load the forced value");

    AST_FF_LOAD: assert property (s_load_edge |=> (e.sr || e.latch || e.q == $past(e.d)))
        else $error("Flip-flop did not load D on the active edge");

    AST_HOLD: assert property (s_hold ##1 (s_hold and !e.latch) |-> $stable(e.q))
        else $error("Disabled element changed its output");

    AST_LATCH_FOLLOW: assert property ((e.latch && e.ce && e.k && !e.sr) |-> e.q == e.d)
        else $error("Transparent latch does not follow D");

    AST_LATCH_HOLD: assert property ((e.latch && !e.sr) ##1 (e.latch && !e.sr && !e.k) |-> $stable(e.q))
        else $error("Opaque latch changed its output");

endmodule // cise_elem

// ### hdl/cise_elem_if.sv
// Interface: control and data of one storage element
`timescale 1ns/1ns
interface cise_elem_if;
    logic k;
    logic ce;
    logic d;
    logic sr;
    logic srval;
    logic latch;
    logic q;
    modport ctl  (output k, ce, d, sr, srval, latch, input q);
    modport elem (input k, ce, d, sr, srval, latch, output q);
endinterface

// ### hdl/cise_pkg.sv
// Package: register map and constants of the cell and I/O storage elements
package cise_pkg;

    // ***************************************
    // Register offsets
    // ***************************************
    localparam int         WB_AW        = 8;
    localparam logic [7:0] ADR_CELL_CFG = 8'h00;
    localparam logic [7:0] ADR_IO_CFG   = 8'h04;
    localparam logic [7:0] ADR_CTRL     = 8'h08;
    localparam logic [7:0] ADR_STATUS   = 8'h0c;
    localparam logic [7:0] ADR_BSCAN    = 8'h10;

    // ***************************************
    // Logic cell configuration fields
    // ***************************************
    localparam int CC_X_LATCH  = 0;
    localparam int CC_Y_LATCH  = 1;
    localparam int CC_X_INV    = 2;
    localparam int CC_Y_INV    = 3;
    localparam int CC_X_CE_TIE = 4;
    localparam int CC_Y_CE_TIE = 5;
    localparam int CC_X_SET    = 6;
    localparam int CC_Y_SET    = 7;
    localparam int CELL_CFG_W  = 8;
    localparam logic [7:0] CELL_CFG_RST = 8'h00;

    // ***************************************
    // I/O cell configuration fields
    // ***************************************
    localparam int IC_CAP_EN     = 0;
    localparam int IC_IN_LATCH   = 1;
    localparam int IC_IN_INV     = 2;
    localparam int IC_OCLK_INV   = 3;
    localparam int IC_OUT_REG    = 4;
    localparam int IC_OUT_INV    = 5;
    localparam int IC_T_INV      = 6;
    localparam int IC_IN_CE_TIE  = 7;
    localparam int IC_OUT_CE_TIE = 8;
    localparam int IC_CAP_SET    = 9;
    localparam int IC_IN_SET     = 10;
    localparam int IC_OUT_SET    = 11;
    localparam int IO_CFG_W      = 12;
    localparam logic [11:0] IO_CFG_RST = 12'h000;

    // ***************************************
    // Control, status and scan fields
    // ***************************************
    localparam int CT_GLOB_PULSE = 0;
    localparam int BS_LEN  = 3;
    localparam int BS_IN   = 0;
    localparam int BS_OUT  = 1;
    localparam int BS_OE   = 2;
    localparam int ST_W    = 7;

endpackage

// ### hdl/cise_top.sv
// Module: logic cell pair and I/O cell storage elements with Wishbone configuration
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
module cise_top
    import cise_pkg::*;
(
    input  logic        CLOCK,
    input  logic        RESET_N,
    input  logic        WB_CYC_I,
    input  logic        WB_STB_I,
    input  logic        WB_WE_I,
    input  logic [7:0]  WB_ADR_I,
    input  logic [3:0]  WB_SEL_I,
    input  logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic        WB_ACK_O,
    input  logic        GLOBAL_SET_RESET,
    input  logic        CELL_CLK,
    input  logic        CELL_CLOCK_ENABLE,
    input  logic        CELL_SET_RESET_INPUT,
    input  logic        CELL_D_X,
    input  logic        CELL_D_Y,
    output logic        CELL_Q_X,
    output logic        CELL_Q_Y,
    input  logic        IO_IN_CLK,
    input  logic        IO_OUT_CLK,
    input  logic        IO_IN_CE,
    input  logic        IO_OUT_CE,
    input  logic        IO_PAD_I,
    output logic        IO_PAD_O,
    output logic        IO_PAD_OE,
    output logic        IO_IN_Q,
    input  logic        IO_OUT_D,
    input  logic        IO_OUT_TRISTATE_CONTROL,
    input  logic        BS_CAPTURE,
    input  logic        BS_SHIFT,
    input  logic        BS_UPDATE,
    input  logic        BS_EXTEST,
    input  logic        BS_TDI,
    output logic        BS_TDO
);

    // ***************************************
    // Declarations
    // ***************************************
    logic [CELL_CFG_W-1:0] cell_cfg_r;
    logic [IO_CFG_W-1:0]   io_cfg_r;
    logic                  glob_pulse_r;
    logic                  ack_r;
    logic [31:0]           dat_r;
    logic [31:0]           rdata;
    logic [31:0]           wr_cell;
    logic [31:0]           wr_io;
    logic                  wr_en;
    logic                  glob_frc;
    logic                  cell_sr;
    logic                  out_data;
    logic                  core_pad_o;
    logic                  core_pad_oe;
    logic [BS_LEN-1:0]     bs_sh_r;
    logic [BS_LEN-1:0]     bs_upd_r;
    logic [ST_W-1:0]       status;

    cise_elem_if ex ();
    cise_elem_if ey ();
    cise_elem_if ecap ();
    cise_elem_if ein ();
    cise_elem_if eout ();

    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ***************************************
    // Wishbone slave
    // ***************************************
    // One wait state: ack follows the request by one edge, then drops
    assign wr_en   = WB_CYC_I & WB_STB_I & WB_WE_I & ~ack_r;
    assign wr_cell = be_merge({24'h0, cell_cfg_r}, WB_DAT_I, WB_SEL_I);
    assign wr_io   = be_merge({20'h0, io_cfg_r}, WB_DAT_I, WB_SEL_I);

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= WB_CYC_I & WB_STB_I & ~ack_r;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            cell_cfg_r <= CELL_CFG_RST;
        end else if (wr_en && WB_ADR_I == ADR_CELL_CFG) begin
            cell_cfg_r <= wr_cell[CELL_CFG_W-1:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            io_cfg_r <= IO_CFG_RST;
        end else if (wr_en && WB_ADR_I == ADR_IO_CFG) begin
            io_cfg_r <= wr_io[IO_CFG_W-1:0];
        end
    end

    // Software pulse of global set/reset lasts exactly one cycle
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            glob_pulse_r <= 1'b0;
        end else begin
            glob_pulse_r <= wr_en && WB_ADR_I == ADR_CTRL && WB_SEL_I[0] && WB_DAT_I[CT_GLOB_PULSE];
        end
    end

    assign status = {core_pad_oe, core_pad_o, ecap.q, eout.q, ein.q, ey.q, ex.q};

    always_comb begin
        case (WB_ADR_I)
            ADR_CELL_CFG: rdata = {24'h0, cell_cfg_r};
            ADR_IO_CFG:   rdata = {20'h0, io_cfg_r};
            ADR_CTRL:     rdata = 32'h0;
            ADR_STATUS:   rdata = {25'h0, status};
            ADR_BSCAN:    rdata = {26'h0, bs_upd_r, bs_sh_r};
            default:      rdata = 32'h0;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            dat_r <= 32'h0;
        end else if (WB_CYC_I && WB_STB_I && !ack_r) begin
            dat_r <= rdata;
        end
    end

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;

    // ***************************************
    // Set/reset distribution
    // ***************************************
    // Reset doubles as power-up so every element starts at its chosen value
    assign glob_frc = ~RESET_N | GLOBAL_SET_RESET | glob_pulse_r;
    assign cell_sr  = glob_frc | CELL_SET_RESET_INPUT;

    // ***************************************
    // Logic cell pair
    // ***************************************
    // Latch mode flips the level so transparency sits on clock low
    assign ex.k     = CELL_CLK ^ cell_cfg_r[CC_X_INV] ^ cell_cfg_r[CC_X_LATCH];
    assign ey.k     = CELL_CLK ^ cell_cfg_r[CC_Y_INV] ^ cell_cfg_r[CC_Y_LATCH];
    assign ex.ce    = CELL_CLOCK_ENABLE | cell_cfg_r[CC_X_CE_TIE];
    assign ey.ce    = CELL_CLOCK_ENABLE | cell_cfg_r[CC_Y_CE_TIE];
    assign ex.d     = CELL_D_X;
    assign ey.d     = CELL_D_Y;
    assign ex.sr    = cell_sr;
    assign ey.sr    = cell_sr;
    assign ex.srval = cell_cfg_r[CC_X_SET];
    assign ey.srval = cell_cfg_r[CC_Y_SET];
    assign ex.latch = cell_cfg_r[CC_X_LATCH];
    assign ey.latch = cell_cfg_r[CC_Y_LATCH];

    cise_elem u_x (
        .clk   (CLOCK),
        .rst_n (RESET_N),
        .e     (ex)
    );

    cise_elem u_y (
        .clk   (CLOCK),
        .rst_n (RESET_N),
        .e     (ey)
    );

    assign CELL_Q_X = ex.q;
    assign CELL_Q_Y = ey.q;

    // ***************************************
    // I/O cell input path
    // ***************************************
    // Capture latch runs off the output clock, transparent while it is low
    assign ecap.k     = ~(IO_OUT_CLK ^ io_cfg_r[IC_OCLK_INV]);
    assign ecap.ce    = 1'b1;
    assign ecap.d     = IO_PAD_I;
    assign ecap.sr    = glob_frc;
    assign ecap.srval = io_cfg_r[IC_CAP_SET];
    assign ecap.latch = 1'b1;

    cise_elem u_cap (
        .clk   (CLOCK),
        .rst_n (RESET_N),
        .e     (ecap)
    );

    // Second stage: rising-edge flop or transparent-high latch
    assign ein.k     = IO_IN_CLK ^ io_cfg_r[IC_IN_INV];
    assign ein.ce    = IO_IN_CE | io_cfg_r[IC_IN_CE_TIE];
    assign ein.d     = io_cfg_r[IC_CAP_EN] ? ecap.q : IO_PAD_I;
    assign ein.sr    = glob_frc;
    assign ein.srval = io_cfg_r[IC_IN_SET];
    assign ein.latch = io_cfg_r[IC_IN_LATCH];

    cise_elem u_in (
        .clk   (CLOCK),
        .rst_n (RESET_N),
        .e     (ein)
    );

    assign IO_IN_Q = ein.q;

    // ***************************************
    // I/O cell output path
    // ***************************************
    assign out_data = IO_OUT_D ^ io_cfg_r[IC_OUT_INV];

    assign eout.k     = IO_OUT_CLK ^ io_cfg_r[IC_OCLK_INV];
    assign eout.ce    = IO_OUT_CE | io_cfg_r[IC_OUT_CE_TIE];
    assign eout.d     = out_data;
    assign eout.sr    = glob_frc;
    assign eout.srval = io_cfg_r[IC_OUT_SET];
    assign eout.latch = 1'b0;

    cise_elem u_out (
        .clk   (CLOCK),
        .rst_n (RESET_N),
        .e     (eout)
    );

    assign core_pad_o  = io_cfg_r[IC_OUT_REG] ? eout.q : out_data;
    assign core_pad_oe = ~(IO_OUT_TRISTATE_CONTROL ^ io_cfg_r[IC_T_INV]);

    // ***************************************
    // Boundary-scan cells
    // ***************************************
    // Chain order TDI -> oe -> out -> in -> TDO
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            bs_sh_r <= '0;
        end else if (BS_CAPTURE) begin
            bs_sh_r <= {core_pad_oe, core_pad_o, IO_PAD_I};
        end else if (BS_SHIFT) begin
            bs_sh_r <= {BS_TDI, bs_sh_r[BS_LEN-1:1]};
        end
    end

    // Update register keeps pins steady while the chain shifts
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            bs_upd_r <= '0;
        end else if (BS_UPDATE) begin
            bs_upd_r <= bs_sh_r;
        end
    end

    assign BS_TDO    = bs_sh_r[BS_IN];
    assign IO_PAD_O  = BS_EXTEST ? bs_upd_r[BS_OUT] : core_pad_o;
    assign IO_PAD_OE = BS_EXTEST ? bs_upd_r[BS_OE] : core_pad_oe;

    // ***************************************
    // Checks
    // ***************************************
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_wb_req;
        WB_CYC_I && WB_STB_I && !ack_r;
    endsequence

    AST_WB_ACK: assert property (s_wb_req |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("Wishbone ack not a single cycle after request");

    AST_TRI: assert property (!BS_EXTEST && IO_OUT_TRISTATE_CONTROL && !io_cfg_r[IC_T_INV] |-> !IO_PAD_OE)
        else $error("Pad driven while tristate control is high");

    AST_OUT_DIRECT: assert property (!BS_EXTEST && !io_cfg_r[IC_OUT_REG] |-> IO_PAD_O == (IO_OUT_D ^ io_cfg_r[IC_OUT_INV]))
        else $error("Direct output path wrong");

    AST_IO_GLOB: assert property (glob_frc |-> eout.q == io_cfg_r[IC_OUT_SET] && ein.q == io_cfg_r[IC_IN_SET])
        else $error("I/O flops not at set/clear value during global set/reset");

    // Enable must be low at the earlier edge, or a legal load shows one cycle later
    AST_IO_NO_SR: assert property (!glob_frc && !eout.ce ##1 !glob_frc |-> $stable(eout.q))
        else $error("Output flop changed while disabled");

    AST_CELL_SR: assert property (CELL_SET_RESET_INPUT |-> CELL_Q_X == cell_cfg_r[CC_X_SET] && CELL_Q_Y == cell_cfg_r[CC_Y_SET])
        else $error("Cell set/reset input did not force outputs");

    AST_CAP_SRC: assert property (io_cfg_r[IC_CAP_EN] |-> ein.d == ecap.q)
        else $error("Input stage not fed from capture latch");

    AST_BS_SHIFT: assert property (BS_SHIFT && !BS_CAPTURE |=> bs_sh_r[BS_LEN-1] == $past(BS_TDI))
        else $error("Scan chain did not take TDI");

endmodule // cise_top

// ### tb/cise_far_model.sv
// Far-side model: board pad with pull-up and one shared board clock
`timescale 1ns/1ns
module cise_far_model (
    input  wire logic clk_src,
    input  wire logic pad_drv,
    input  wire logic pad_en,
    input  wire logic ext_en,
    input  wire logic ext_val,
    output logic      early_clk,
    output logic      lowskew_clk,
    output logic      pad_lvl
);
    // One pad feeds both buffers, so the two stages see no skew
    assign early_clk   = clk_src;
    assign lowskew_clk = clk_src;
    // Released pad with ext_en low is pulled high, never left at the last driven value
    assign pad_lvl = pad_en ? pad_drv : (ext_en ? ext_val : 1'b1);
endmodule // cise_far_model

// ### tb/cise_top_bench.sv
// Testbench: storage element scenarios through pins and Wishbone registers
`timescale 1ns/1ns
module cise_top_bench;
    import cise_pkg::*;
    logic        clock, rst_n, cyc, stb, we, ack, gfrc, kclk, ce, sr, dx, dy;
    logic        ioclk, ice, oce, od, tsc, cap, shf, tdi, ext_en, ext, upd, xt;
    logic        qx, qy, pad_o, oe, in_q, tdo, in_clk, out_clk, pad_lvl;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, dat_o;
    int          err_total, n_compared;

    cise_top DUT (
        .CLOCK(clock), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .GLOBAL_SET_RESET(gfrc), .CELL_CLK(kclk), .CELL_CLOCK_ENABLE(ce),
        .CELL_SET_RESET_INPUT(sr), .CELL_D_X(dx), .CELL_D_Y(dy), .CELL_Q_X(qx), .CELL_Q_Y(qy),
        .IO_IN_CLK(in_clk), .IO_OUT_CLK(out_clk), .IO_IN_CE(ice), .IO_OUT_CE(oce),
        .IO_PAD_I(pad_lvl), .IO_PAD_O(pad_o), .IO_PAD_OE(oe), .IO_IN_Q(in_q),
        .IO_OUT_D(od), .IO_OUT_TRISTATE_CONTROL(tsc), .BS_CAPTURE(cap), .BS_SHIFT(shf),
        .BS_UPDATE(upd), .BS_EXTEST(xt), .BS_TDI(tdi), .BS_TDO(tdo)
    );
    cise_far_model FAR (
        .clk_src(ioclk), .pad_drv(pad_o), .pad_en(oe), .ext_en(ext_en), .ext_val(ext),
        .early_clk(out_clk), .lowskew_clk(in_clk), .pad_lvl(pad_lvl)
    );

    // ***************************************
    // Helpers
    // ***************************************
    always #4 clock = ~clock;

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task tally_and_finish;
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Holds the request until ack is sampled; no fixed latency assumed
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk("wb_ack", 32'h1, 32'h0);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask

    task look;
        @(negedge clock);
    endtask

    // Levels held several cycles so the sampled clock sees each one
    task tog(input logic io, input logic a);
        @(posedge clock);
        if (io) begin
            ioclk <= a;
        end else begin
            kclk <= a;
        end
        repeat (2) @(posedge clock);
        if (io) begin
            ioclk <= ~a;
        end else begin
            kclk <= ~a;
        end
        repeat (3) @(posedge clock);
        look();
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        tally_and_finish();
    end

    // ***************************************
    // Scenarios
    // ***************************************
    initial begin
        {clock, rst_n, cyc, stb, we, gfrc, kclk, ce, sr, dx, dy, ioclk, ice, oce} = '0;
        {od, tsc, cap, shf, tdi, ext_en, ext, upd, xt, adr, sel, wdat} = '0;
        err_total = 0;
        n_compared = 0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        look();
        chk("q_x_reset", 32'h0, qx);
        rdc("cell_cfg_reset", ADR_CELL_CFG, {24'h0, CELL_CFG_RST});
        rdc("io_cfg_reset", ADR_IO_CFG, {20'h0, IO_CFG_RST});
        rdc("unmapped", 8'h40, 32'h0);
        @(posedge clock);
        ce <= 1'b1;
        dx <= 1'b1;
        tog(1'b0, 1'b0);
        chk("q_x_load", 32'h1, qx);
        chk("q_y_load", 32'h0, qy);
        @(posedge clock);
        ce <= 1'b0;
        dx <= 1'b0;
        dy <= 1'b1;
        tog(1'b0, 1'b0);
        chk("q_x_ce_low", 32'h1, qx);
        chk("q_y_ce_low", 32'h0, qy);
        wb(1'b1, ADR_CELL_CFG, 32'h1 << CC_X_CE_TIE);
        tog(1'b0, 1'b0);
        chk("q_x_ce_tied", 32'h0, qx);
        chk("q_y_not_tied", 32'h0, qy);
        wb(1'b1, ADR_CELL_CFG, 32'h1 << CC_X_INV);
        @(posedge clock);
        ce <= 1'b1;
        dx <= 1'b1;
        tog(1'b0, 1'b1);
        chk("q_x_fall_edge", 32'h1, qx);
        chk("q_y_no_fall", 32'h0, qy);
        wb(1'b1, ADR_CELL_CFG, 32'h1 << CC_X_LATCH);
        @(posedge clock);
        dx <= 1'b0;
        repeat (2) look();
        chk("latch_open", 32'h0, qx);
        @(posedge clock);
        kclk <= 1'b1;
        repeat (2) @(posedge clock);
        dx <= 1'b1;
        repeat (2) look();
        chk("latch_closed", 32'h0, qx);
        @(posedge clock);
        kclk <= 1'b0;
        repeat (2) look();
        chk("latch_reopen", 32'h1, qx);
        wb(1'b1, ADR_CELL_CFG, 32'h1 << CC_X_SET);
        @(posedge clock);
        dx <= 1'b0;
        sr <= 1'b1;
        repeat (2) look();
        chk("sr_set_x", 32'h1, qx);
        chk("sr_clear_y", 32'h0, qy);
        @(posedge clock);
        sr <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, ADR_IO_CFG, 32'(i >> 1) << IC_OUT_INV);
            @(posedge clock);
            od <= i[0];
            repeat (2) look();
            chk("pad_direct", 32'(i[0] ^ i[1]), pad_o);
            chk("oe_driven", 32'h1, oe);
        end
        @(posedge clock);
        tsc <= 1'b1;
        repeat (2) look();
        chk("oe_float", 32'h0, oe);
        wb(1'b1, ADR_IO_CFG, 32'h1 << IC_T_INV);
        look();
        chk("oe_t_inv", 32'h1, oe);
        wb(1'b1, ADR_IO_CFG, 32'h1 << IC_OUT_REG);
        @(posedge clock);
        tsc <= 1'b0;
        od <= 1'b1;
        oce <= 1'b1;
        tog(1'b1, 1'b0);
        chk("out_flop_load", 32'h1, pad_o);
        @(posedge clock);
        oce <= 1'b0;
        od <= 1'b0;
        sr <= 1'b1;
        tog(1'b1, 1'b0);
        chk("out_flop_hold", 32'h1, pad_o);
        @(posedge clock);
        sr <= 1'b0;
        gfrc <= 1'b1;
        repeat (2) look();
        chk("glob_out_clear", 32'h0, pad_o);
        chk("glob_x_set", 32'h1, qx);
        @(posedge clock);
        gfrc <= 1'b0;
        wb(1'b1, ADR_IO_CFG, (32'h1 << IC_OUT_REG) | (32'h1 << IC_OUT_SET));
        wb(1'b1, ADR_CELL_CFG, 32'h0);
        wb(1'b1, ADR_CTRL, 32'h1 << CT_GLOB_PULSE);
        repeat (3) look();
        chk("pulse_out_set", 32'h1, pad_o);
        chk("pulse_x_clear", 32'h0, qx);
        rdc("ctrl_reads_zero", ADR_CTRL, 32'h0);
        wb(1'b1, ADR_IO_CFG, (32'h1 << IC_CAP_EN) | (32'h1 << IC_IN_LATCH) | (32'h1 << IC_IN_CE_TIE));
        @(posedge clock);
        tsc <= 1'b1;
        ext_en <= 1'b1;
        ext <= 1'b1;
        tog(1'b1, 1'b0);
        chk("cap_latch_in", 32'h1, in_q);
        @(posedge clock);
        ext <= 1'b0;
        repeat (3) look();
        chk("cap_latch_hold", 32'h1, in_q);
        tog(1'b1, 1'b0);
        chk("cap_latch_next", 32'h0, in_q);
        wb(1'b1, ADR_IO_CFG, (32'h1 << IC_CAP_EN) | (32'h1 << IC_IN_CE_TIE));
        @(posedge clock);
        ext <= 1'b1;
        tog(1'b1, 1'b0);
        chk("cap_flop", 32'h1, in_q);
        wb(1'b1, ADR_IO_CFG, (32'h1 << IC_IN_INV) | (32'h1 << IC_IN_CE_TIE));
        @(posedge clock);
        ext <= 1'b0;
        tog(1'b1, 1'b1);
        chk("in_inv_fall", 32'h0, in_q);
        @(posedge clock);
        ext <= 1'b1;
        tog(1'b1, 1'b0);
        chk("in_inv_no_rise", 32'h0, in_q);
        wb(1'b1, ADR_IO_CFG, 32'h0);
        @(posedge clock);
        od <= 1'b1;
        ext <= 1'b0;
        cap <= 1'b1;
        @(posedge clock);
        cap <= 1'b0;
        rdc("scan_capture", ADR_BSCAN, 32'h2);
        @(posedge clock);
        tdi <= 1'b1;
        shf <= 1'b1;
        @(posedge clock);
        shf <= 1'b0;
        rdc("scan_shift", ADR_BSCAN, 32'h5);
        chk("scan_tdo", 32'h1, tdo);
        // Core oe 0, core out 1, capture 1, out flop 1, in 0, cell pair 0
        rdc("status", ADR_STATUS, 32'h38);
        @(posedge clock);
        upd <= 1'b1;
        @(posedge clock);
        upd <= 1'b0;
        rdc("scan_update", ADR_BSCAN, 32'h2d);
        @(posedge clock);
        xt <= 1'b1;
        repeat (2) look();
        chk("extest_pad", 32'h0, pad_o);
        chk("extest_oe", 32'h1, oe);
        tally_and_finish();
    end
endmodule // cise_top_bench
